// ===== hdl/cll_lock_ctrl.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cll_regs.svh"

module cll_lock_ctrl #(
    parameter int INDEX_W = 8,
    parameter int TAG_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    cll_if.dev link
);
    localparam int DEPTH = 1 << INDEX_W;

    // Per cache, per set, per index state, LRU per cache and index only; cache 0 is data, 1 is instruction
    logic valid_reg [0:1][0:1][0:DEPTH-1];
    logic lock_reg [0:1][0:1][0:DEPTH-1];
    logic [TAG_W-1:0] tag_reg [0:1][0:1][0:DEPTH-1];
    logic lru_reg [0:1][0:DEPTH-1];
    logic rsp_valid_reg;
    logic rsp_hit_reg;
    logic rsp_set_reg;
    logic rsp_locked_reg;

    // Victim choice: a locked set is never given up, then an invalid set,
    // then the least recently used one
    function automatic logic pick_victim(
        input logic l0,
        input logic l1,
        input logic v0,
        input logic v1,
        input logic lru
    );
        logic s;
        s = lru;
        if (l0)
            s = 1'b1;
        else if (l1)
            s = 1'b0;
        else if (!v0)
            s = 1'b0;
        else if (!v1)
            s = 1'b1;
        return s;
    endfunction

    // Tag compare of one set; a stale tag behind a cleared valid bit never hits
    function automatic logic tag_hit(
        input logic valid,
        input logic [TAG_W-1:0] stored,
        input logic [TAG_W-1:0] probe
    );
        return valid && (stored == probe);
    endfunction

    // Lock enable of the addressed cache; the other cache's enable has no say
    function automatic logic lock_enable(
        input logic [31:0] word,
        input logic icache
    );
        logic en;
        if (icache)
            en = (word & `CLL_IL_SET_MASK) != 32'h0000_0000;
        else
            en = (word & `CLL_DL_SET_MASK) != 32'h0000_0000;
        return en;
    endfunction

    logic c;
    logic [INDEX_W-1:0] idx;
    logic v0, v1, l0, l1, hit0, hit1, hit, hit_set, victim, lock_en;
    logic do_write, do_inval, tgt_set, tgt_lock;

    // Lookup of the addressed index in the selected cache
    always_comb
    begin
        c = link.req_icache;
        idx = link.req_index;
        v0 = valid_reg[c][0][idx];
        v1 = valid_reg[c][1][idx];
        l0 = lock_reg[c][0][idx];
        l1 = lock_reg[c][1][idx];
        hit0 = tag_hit(v0, tag_reg[c][0][idx], link.req_tag);
        hit1 = tag_hit(v1, tag_reg[c][1][idx], link.req_tag);
        hit = hit0 || hit1;
        hit_set = hit1;
        victim = pick_victim(l0, l1, v0, v1, lru_reg[c][idx]);
        // Enables are read from the live status word; no hazard cover here,
        // so a request in the cycle after the write already sees the new value
        lock_en = lock_enable(link.status_word, c);
    end

    // Decide which set is written and what its lock becomes
    always_comb
    begin
        do_write = 1'b0;
        do_inval = 1'b0;
        tgt_set = hit ? hit_set : victim;
        tgt_lock = lock_reg[c][tgt_set][idx];
        if (link.req_valid)
        begin
            unique case (link.req_op)
                cll_pkg::CLL_OP_LOAD:
                    do_write = !hit;
                cll_pkg::CLL_OP_FILL:
                    do_write = 1'b1;
                cll_pkg::CLL_OP_STORE:
                    do_write = 1'b0;
                cll_pkg::CLL_OP_INVAL:
                    do_inval = hit;
            endcase
        end
        // A line becoming valid may lock only if neither set is locked yet
        if (do_write && lock_en && !(l0 || l1))
            tgt_lock = 1'b1;
    end

    // Valid bits; reset clears so fills start from set 0
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < 2; k++)
                for (int s = 0; s < 2; s++)
                    for (int i = 0; i < DEPTH; i++)
                        valid_reg[k][s][i] <= 1'b0;
        end
        else if (do_write)
            valid_reg[c][tgt_set][idx] <= 1'b1;
        else if (do_inval)
            valid_reg[c][hit_set][idx] <= 1'b0;
    end

    // Lock flags follow the valid bit down in the same edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < 2; k++)
                for (int s = 0; s < 2; s++)
                    for (int i = 0; i < DEPTH; i++)
                        lock_reg[k][s][i] <= 1'b0;
        end
        else if (do_write)
            lock_reg[c][tgt_set][idx] <= tgt_lock;
        else if (do_inval)
            lock_reg[c][hit_set][idx] <= 1'b0;
    end

    // Tags carry no control meaning and are only trusted when valid
    always_ff @(posedge clk)
    begin
        if (do_write)
            tag_reg[c][tgt_set][idx] <= link.req_tag;
    end

    // Touching a set makes the other one the replacement candidate
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < 2; k++)
                for (int i = 0; i < DEPTH; i++)
                    lru_reg[k][i] <= 1'b0;
        end
        else if (do_write || (link.req_valid && hit && link.req_op != cll_pkg::CLL_OP_INVAL))
            lru_reg[c][idx] <= ~tgt_set;
    end

    // Answer one edge after the request, from the state before the update
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_hit_reg <= 1'b0;
            rsp_set_reg <= 1'b0;
            rsp_locked_reg <= 1'b0;
        end
        else
        begin
            rsp_valid_reg <= link.req_valid;
            if (link.req_valid)
            begin
                rsp_hit_reg <= hit;
                rsp_set_reg <= do_inval ? hit_set : tgt_set;
                rsp_locked_reg <= do_inval ? 1'b0 : ((do_write || hit) && tgt_lock);
            end
        end
    end

    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_hit = rsp_hit_reg;
    assign link.rsp_set = rsp_set_reg;
    assign link.rsp_locked = rsp_locked_reg;
endmodule

// ===== hdl/cll_pipe_host.sv
`timescale 1ns/1ps
`include "cll_regs.svh"

module cll_pipe_host #(
    parameter int INDEX_W = 8,
    parameter int TAG_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    cll_if.pipe link
);
    cll_pkg::cll_state_t state_reg;
    logic [31:0] status_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic req_valid_reg;
    cll_pkg::cll_op_t op_reg;
    logic icache_reg;
    logic [INDEX_W-1:0] index_reg;
    logic [TAG_W-1:0] tag_reg;
    logic hit_reg, set_reg, locked_reg, done_reg;
    logic access, wr_done, mapped, cmd_go;

    always_comb
    begin
        access = psel && penable;
        wr_done = access && pready_reg && pwrite;
        mapped = (paddr == `CLL_OFF_STATUS) || (paddr == `CLL_OFF_CMD) || (paddr == `CLL_OFF_RESULT);
        // A command written while one is in flight is dropped
        cmd_go = wr_done && (paddr == `CLL_OFF_CMD) && (state_reg == cll_pkg::CLL_ST_IDLE);
    end

    // One wait state: ready is raised in the second access cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else if (access && !pready_reg)
        begin
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg <= 32'h0000_0000;
            if (!pwrite && paddr == `CLL_OFF_STATUS)
                prdata_reg <= status_reg;
            else if (!pwrite && paddr == `CLL_OFF_CMD)
                prdata_reg <= {tag_reg, index_reg, 5'h00, icache_reg, op_reg};
            else if (!pwrite && paddr == `CLL_OFF_RESULT)
                prdata_reg <= {27'h000_0000, done_reg, locked_reg, set_reg, hit_reg,
                               state_reg != cll_pkg::CLL_ST_IDLE};
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Status word: software sets or clears lock enables by OR and AND masks
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            status_reg <= `CLL_STATUS_RST;
        else if (wr_done && paddr == `CLL_OFF_STATUS)
            status_reg <= pwdata;
    end

    // Command latch
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            op_reg <= cll_pkg::CLL_OP_LOAD;
            icache_reg <= 1'b0;
            index_reg <= '0;
            tag_reg <= '0;
        end
        else if (cmd_go)
        begin
            op_reg <= cll_pkg::cll_op_t'(pwdata[`CLL_CMD_OP_LSB +: `CLL_CMD_OP_W]);
            icache_reg <= pwdata[`CLL_CMD_ICACHE_BIT];
            index_reg <= pwdata[`CLL_CMD_INDEX_LSB +: INDEX_W];
            tag_reg <= pwdata[`CLL_CMD_TAG_LSB +: TAG_W];
        end
    end

    // Sequencer: issue one request pulse, then wait for the answer
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= cll_pkg::CLL_ST_IDLE;
            req_valid_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                cll_pkg::CLL_ST_IDLE:
                    if (cmd_go)
                    begin
                        state_reg <= cll_pkg::CLL_ST_ISSUE;
                        req_valid_reg <= 1'b1;
                    end
                cll_pkg::CLL_ST_ISSUE:
                begin
                    state_reg <= cll_pkg::CLL_ST_WAIT;
                    req_valid_reg <= 1'b0;
                end
                cll_pkg::CLL_ST_WAIT:
                    if (link.rsp_valid)
                        state_reg <= cll_pkg::CLL_ST_IDLE;
                default:
                begin
                    state_reg <= cll_pkg::CLL_ST_IDLE;
                    req_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    // Result capture; done is sticky until the next command, set wins
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hit_reg <= 1'b0;
            set_reg <= 1'b0;
            locked_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (state_reg == cll_pkg::CLL_ST_WAIT && link.rsp_valid)
        begin
            hit_reg <= link.rsp_hit;
            set_reg <= link.rsp_set;
            locked_reg <= link.rsp_locked;
            done_reg <= 1'b1;
        end
        else if (cmd_go)
            done_reg <= 1'b0;
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign link.req_valid = req_valid_reg;
    assign link.req_op = op_reg;
    assign link.req_icache = icache_reg;
    assign link.req_index = index_reg;
    assign link.req_tag = tag_reg;
    assign link.status_word = status_reg;
endmodule

// ===== inc/cll_if.sv
`timescale 1ns/1ps

interface cll_if #(
    parameter int INDEX_W = 8,
    parameter int TAG_W = 16
);
    logic req_valid;
    cll_pkg::cll_op_t req_op;
    logic req_icache;
    logic [INDEX_W-1:0] req_index;
    logic [TAG_W-1:0] req_tag;
    logic [31:0] status_word;
    logic rsp_valid;
    logic rsp_hit;
    logic rsp_set;
    logic rsp_locked;

    modport dev
    (
        input req_valid,
        input req_op,
        input req_icache,
        input req_index,
        input req_tag,
        input status_word,
        output rsp_valid,
        output rsp_hit,
        output rsp_set,
        output rsp_locked
    );

    modport pipe
    (
        output req_valid,
        output req_op,
        output req_icache,
        output req_index,
        output req_tag,
        output status_word,
        input rsp_valid,
        input rsp_hit,
        input rsp_set,
        input rsp_locked
    );
endinterface

// ===== inc/cll_pkg.sv
package cll_pkg;

    // Operations the pipeline presents to the lock controller
    typedef enum logic [1:0]
    {
        CLL_OP_LOAD = 2'h0,
        CLL_OP_FILL = 2'h1,
        CLL_OP_STORE = 2'h2,
        CLL_OP_INVAL = 2'h3
    } cll_op_t;

    // Pipeline-side command sequencer
    typedef enum logic [2:0]
    {
        CLL_ST_IDLE = 3'b001,
        CLL_ST_ISSUE = 3'b010,
        CLL_ST_WAIT = 3'b100
    } cll_state_t;

endpackage

// ===== inc/cll_regs.svh
`ifndef CLL_REGS_SVH
`define CLL_REGS_SVH

// Lock enable bits of the status register and the masks software uses
`define CLL_DL_SET_MASK 32'h0010_0000
`define CLL_DL_CLR_MASK 32'hffef_ffff
`define CLL_IL_SET_MASK 32'h0008_0000
`define CLL_IL_CLR_MASK 32'hfff7_ffff
`define CLL_STATUS_RST 32'h0000_0000

// APB register offsets, byte addresses
`define CLL_OFF_STATUS 8'h00
`define CLL_OFF_CMD 8'h04
`define CLL_OFF_RESULT 8'h08

// Command word fields
`define CLL_CMD_OP_LSB 0
`define CLL_CMD_OP_W 2
`define CLL_CMD_ICACHE_BIT 2
`define CLL_CMD_INDEX_LSB 8
`define CLL_CMD_TAG_LSB 16

// Result word fields
`define CLL_RES_BUSY_BIT 0
`define CLL_RES_HIT_BIT 1
`define CLL_RES_SET_BIT 2
`define CLL_RES_LOCKED_BIT 3
`define CLL_RES_DONE_BIT 4

`endif

// ===== test/cache_line_lock_control_test.sv
`timescale 1ns/1ps
`include "cll_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end

module cache_line_lock_control_test;
    localparam cll_pkg::cll_op_t ld = cll_pkg::CLL_OP_LOAD;
    localparam cll_pkg::cll_op_t fl = cll_pkg::CLL_OP_FILL;
    localparam cll_pkg::cll_op_t stw = cll_pkg::CLL_OP_STORE;
    localparam cll_pkg::cll_op_t inv = cll_pkg::CLL_OP_INVAL;
    logic clk;
    logic sys_rst;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic er;
    int n_errors;
    int total_checks;

    cll_if link ();
    cll_lock_ctrl u_cll_lock_ctrl (.clk(clk), .sys_rst(sys_rst), .link(link.dev));
    cll_pipe_host u_cll_pipe_host (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.pipe));
    cll_link_sva #(.INDEX_W(8), .TAG_W(16)) u_cll_link_sva (.clk(clk), .sys_rst(sys_rst),
        .req_valid(link.req_valid), .req_op(link.req_op), .req_icache(link.req_icache),
        .req_index(link.req_index), .req_tag(link.req_tag), .status_word(link.status_word),
        .rsp_valid(link.rsp_valid), .rsp_hit(link.rsp_hit), .rsp_set(link.rsp_set), .rsp_locked(link.rsp_locked));

    task complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write STATUS and read it back
    task automatic st(input logic [31:0] v);
        apb(`CLL_OFF_STATUS, 1'b1, v);
        apb(`CLL_OFF_STATUS, 1'b0, 32'h0000_0000);
        `CHK(rd, v)
        `CHK(er, 1'b0)
    endtask

    // Issue a command, poll RESULT until done, compare hit, set, locked
    task automatic op(input cll_pkg::cll_op_t o, input logic ic, input logic [7:0] ix, input logic [15:0] tg,
        input logic h, input logic s, input logic l);
        int i;
        apb(`CLL_OFF_CMD, 1'b1, {tg, ix, 5'h00, ic, o});
        for (i = 0; i < 20; i++)
        begin
            apb(`CLL_OFF_RESULT, 1'b0, 32'h0000_0000);
            if (rd[`CLL_RES_DONE_BIT] === 1'b1 && rd[`CLL_RES_BUSY_BIT] === 1'b0)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            complete_run();
        end
        `CHK(rd[4:0], {1'b1, l, s, h, 1'b0})
    endtask

    // Reset state and an unmapped address
    task t_reset;
        apb(`CLL_OFF_STATUS, 1'b0, 32'h0000_0000);
        `CHK(rd, `CLL_STATUS_RST)
        apb(8'h0c, 1'b1, 32'h0000_0001);
        `CHK(er, 1'b1)
        apb(8'h0c, 1'b0, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        op(ld, 1'b0, 8'h03, 16'h0001, 1'b0, 1'b0, 1'b0);
        apb(`CLL_OFF_CMD, 1'b0, 32'h0000_0000);
        `CHK(rd, {16'h0001, 8'h03, 5'h00, 1'b0, 2'h0})
    endtask

    // Data locking: lock once, second lock ignored, locked set never a victim
    task t_data;
        st(`CLL_DL_SET_MASK);
        op(fl, 1'b1, 8'h0b, 16'h0055, 1'b0, 1'b0, 1'b0);
        op(ld, 1'b0, 8'h05, 16'h00a1, 1'b0, 1'b0, 1'b1);
        op(ld, 1'b0, 8'h05, 16'h00b2, 1'b0, 1'b1, 1'b0);
        op(ld, 1'b0, 8'h05, 16'h00c3, 1'b0, 1'b1, 1'b0);
        op(stw, 1'b0, 8'h05, 16'h00a1, 1'b1, 1'b0, 1'b1);
        op(ld, 1'b0, 8'h05, 16'h00a1, 1'b1, 1'b0, 1'b1);
        st(`CLL_DL_SET_MASK & `CLL_DL_CLR_MASK);
        op(ld, 1'b0, 8'h05, 16'h00d4, 1'b0, 1'b1, 1'b0);
        op(inv, 1'b0, 8'h05, 16'h00a1, 1'b1, 1'b0, 1'b0);
        op(ld, 1'b0, 8'h05, 16'h00e5, 1'b0, 1'b0, 1'b0);
    endtask

    // Instruction locking through the fill operation
    task t_instr;
        st(`CLL_IL_SET_MASK);
        op(ld, 1'b0, 8'h07, 16'h0011, 1'b0, 1'b0, 1'b0);
        op(fl, 1'b1, 8'h07, 16'h0022, 1'b0, 1'b0, 1'b1);
        op(fl, 1'b1, 8'h07, 16'h0033, 1'b0, 1'b1, 1'b0);
        op(fl, 1'b1, 8'h07, 16'h0022, 1'b1, 1'b0, 1'b1);
        op(inv, 1'b1, 8'h07, 16'h0022, 1'b1, 1'b0, 1'b0);
        op(fl, 1'b1, 8'h07, 16'h0044, 1'b0, 1'b0, 1'b1);
        st(`CLL_IL_SET_MASK & `CLL_IL_CLR_MASK);
    endtask

    // Unlocked index: invalid set first, then least recently used
    task t_lru;
        op(ld, 1'b0, 8'h09, 16'h0001, 1'b0, 1'b0, 1'b0);
        op(ld, 1'b0, 8'h09, 16'h0002, 1'b0, 1'b1, 1'b0);
        op(ld, 1'b0, 8'h09, 16'h0001, 1'b1, 1'b0, 1'b0);
        op(ld, 1'b0, 8'h09, 16'h0003, 1'b0, 1'b1, 1'b0);
        op(stw, 1'b0, 8'h09, 16'h0003, 1'b1, 1'b1, 1'b0);
        op(ld, 1'b0, 8'h09, 16'h0004, 1'b0, 1'b0, 1'b0);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, well above the longest legal run
    initial
    begin
        #100000;
        n_errors++;
        complete_run();
    end

    initial
    begin
        n_errors = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_data();
        t_instr();
        t_lru();
        complete_run();
    end
endmodule

// ===== test/cll_link_sva.sv
`timescale 1ns/1ps
`include "cll_regs.svh"

module cll_link_sva #(
    parameter int INDEX_W = 8,
    parameter int TAG_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire cll_pkg::cll_op_t req_op,
    input wire logic req_icache,
    input wire logic [INDEX_W-1:0] req_index,
    input wire logic [TAG_W-1:0] req_tag,
    input wire logic [31:0] status_word,
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic rsp_set,
    input wire logic rsp_locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Request and answer timing on the link
    property p_rsp_after_req; req_valid |=> rsp_valid; endproperty
    a_rsp_after_req: assert property (p_rsp_after_req) else $error("no answer after request");
    property p_no_rsp_idle; !req_valid |=> !rsp_valid; endproperty
    a_no_rsp_idle: assert property (p_no_rsp_idle) else $error("answer without request");
    property p_req_pulse; req_valid |=> !req_valid [*2]; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request not single or not spaced");
    property p_fields_hold; !req_valid |-> $stable({req_op, req_icache, req_index, req_tag}); endproperty
    a_fields_hold: assert property (p_fields_hold) else $error("request fields moved between commands");
    property p_rsp_hold; !rsp_valid |-> $stable({rsp_hit, rsp_set, rsp_locked}); endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("answer fields moved between answers");

    // Invalidate always leaves the line unlocked
    property p_inval_unlock; req_valid && req_op == cll_pkg::CLL_OP_INVAL |=> !rsp_locked; endproperty
    a_inval_unlock: assert property (p_inval_unlock) else $error("invalidated line still locked");

    // A new lock on a miss needs the enable of that cache, and only that one
    property p_dlock_en;
        req_valid && !req_icache && req_op != cll_pkg::CLL_OP_INVAL &&
            (status_word & `CLL_DL_SET_MASK) == 32'h0000_0000 |=> rsp_hit || !rsp_locked;
    endproperty
    a_dlock_en: assert property (p_dlock_en) else $error("data line locked without its enable");
    property p_ilock_en;
        req_valid && req_icache && req_op != cll_pkg::CLL_OP_INVAL &&
            (status_word & `CLL_IL_SET_MASK) == 32'h0000_0000 |=> rsp_hit || !rsp_locked;
    endproperty
    a_ilock_en: assert property (p_ilock_en) else $error("instr line locked without its enable");
endmodule
